// ### hdl/block_input_repeat.sv
// execution engine of the repeating block input instructions (byte and word forms)
//
// Overview of operation
// [RL1] each item: read port, store at pointer, decrement count, repeat until zero
// [RL2] memory fills at ascending addresses from the starting pointer value
// [RL3] port register drives address bits 7..0 of each input transaction
// [RL4] count drives address bits 15..8, I/O page drives bits 23..16
// [RL5] returned byte or word is written where the pointer points
// [RL6] pointer advances by one for bytes, by two for words
// [RL7] after each decrement, finish at zero count, otherwise input again
// [RL8] a zero count at start yields 256 items
// [RL9] an interrupt may be accepted between any two items
// [RL10] instruction start address is saved before the interrupt is accepted
// [RL11] completion sets zero and subtract flags, others unchanged
// [RL12] with user I/O inhibited the instruction traps instead of transferring
// [RL13] byte form is prefix ED then opcode B2
// [RL14] word form is prefix ED then opcode 92
// [RL15] the privilege check applies only in user mode
// [RL16] the peripheral returns one item per transaction, in order
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "block_input_regs.svh"

module block_input_repeat (
	input wire logic SYS_CLK_I,
	input wire logic RESET_I,
	input wire logic [`BIR_ADDR_W-1:0] ADDR_I,
	input wire logic [31:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [31:0] RDATA_O,
	input wire logic START_I,
	input wire logic [7:0] PREFIX_I,
	input wire logic [7:0] OPCODE_I,
	input wire logic [15:0] PC_I,
	input wire logic IRQ_REQ_I,
	input wire logic IO_RVALID_I,
	input wire logic [15:0] IO_RDATA_I,
	output block_input_pkg::io_req_t IO_REQ_O,
	output block_input_pkg::mem_wr_t MEM_WR_O,
	output logic BUSY_O,
	output logic DONE_O,
	output logic TRAP_O,
	output logic IRQ_TAKEN_O,
	output logic [15:0] SAVED_PC_O,
	output logic INT_O
);

	block_input_pkg::state_t state_r;
	block_input_pkg::insn_t insn;
	logic [1:0] ctrl_r;
	logic [7:0] count_r;
	logic [7:0] port_r;
	logic [7:0] page_r;
	logic [15:0] pointer_r;
	logic [7:0] flags_r;
	logic [`BIR_ST_W-1:0] status_r;
	logic [`BIR_ST_W-1:0] mask_r;
	logic [15:0] pc_r;
	logic word_r;
	logic begin_ok;
	logic begin_trap;
	logic item_in;
	logic last_item;
	logic [7:0] count_nxt;
	logic [15:0] pointer_nxt;
	logic [`BIR_ST_W-1:0] ev;

	function automatic logic wr_hit(input logic [`BIR_ADDR_W-1:0] ofs);
		wr_hit = WR_I && (ADDR_I == ofs);
	endfunction

	block_input_decode u_decode (
		.prefix_i(PREFIX_I),
		.opcode_i(OPCODE_I),
		.insn_o(insn)
	);

	// [RL15] only user mode checks inhibit
	assign begin_trap = START_I && insn.valid && (state_r == block_input_pkg::ST_IDLE) &&
		ctrl_r[`BIR_CTRL_USER] && ctrl_r[`BIR_CTRL_INHIBIT];
	assign begin_ok = START_I && insn.valid && (state_r == block_input_pkg::ST_IDLE) && !begin_trap;
	// [RL16] an answer counts only after its request has gone out
	assign item_in = (state_r == block_input_pkg::ST_WAIT) && IO_RVALID_I && !IO_REQ_O.valid;
	// [RL8] zero wraps to FF, so 256 items run
	assign count_nxt = count_r - 8'h01;
	// [RL6] step one or two
	assign pointer_nxt = pointer_r + (word_r ? 16'h0002 : 16'h0001);
	assign last_item = (count_nxt == 8'h00);

	// engine sequencing
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			state_r <= block_input_pkg::ST_IDLE;
			word_r <= 1'b0;
			pc_r <= `BIR_RST_POINTER;
		end else begin
			unique case (state_r)
				block_input_pkg::ST_IDLE: begin
					if (begin_ok) begin
						state_r <= block_input_pkg::ST_WAIT;
						word_r <= insn.word;
						pc_r <= PC_I;
					end
				end
				block_input_pkg::ST_WAIT: begin
					// [RL7] stop at zero
					// [RL9] leave between items on interrupt
					if (item_in && (last_item || IRQ_REQ_I)) begin
						state_r <= block_input_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// bus transactions toward the peripheral
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			IO_REQ_O <= '0;
		end else begin
			IO_REQ_O.valid <= begin_ok || (item_in && !last_item && !IRQ_REQ_I);
			if (begin_ok) begin
				IO_REQ_O.word <= insn.word;
				// [RL3] [RL4] page, count, port on the address
				IO_REQ_O.addr <= {page_r, count_r, port_r};
			end else if (item_in) begin
				IO_REQ_O.addr <= {page_r, count_nxt, port_r};
			end
		end
	end

	// memory stores
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			MEM_WR_O <= '0;
		end else begin
			// [RL5] store at current pointer
			MEM_WR_O.we <= item_in;
			if (item_in) begin
				MEM_WR_O.word <= word_r;
				MEM_WR_O.addr <= pointer_r;
				MEM_WR_O.data <= word_r ? IO_RDATA_I : {8'h00, IO_RDATA_I[7:0]};
			end
		end
	end

	// count, pointer and operand registers; software writes are ignored while busy, except writes to the control register
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			ctrl_r <= `BIR_RST_CTRL;
			count_r <= `BIR_RST_BYTE;
			port_r <= `BIR_RST_BYTE;
			page_r <= `BIR_RST_BYTE;
			pointer_r <= `BIR_RST_POINTER;
		end else begin
			if (wr_hit(`BIR_OFS_CTRL)) begin
				ctrl_r <= WDATA_I[1:0];
			end
			if (wr_hit(`BIR_OFS_PORT) && !BUSY_O) begin
				port_r <= WDATA_I[7:0];
			end
			if (wr_hit(`BIR_OFS_PAGE) && !BUSY_O) begin
				page_r <= WDATA_I[7:0];
			end
			if (item_in) begin
				// [RL1] decrement per item
				count_r <= count_nxt;
				// [RL2] ascending fill
				pointer_r <= pointer_nxt;
			end else if (!BUSY_O) begin
				if (wr_hit(`BIR_OFS_COUNT)) begin
					count_r <= WDATA_I[7:0];
				end
				if (wr_hit(`BIR_OFS_POINTER)) begin
					pointer_r <= WDATA_I[15:0];
				end
			end
		end
	end

	// processor flags
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			flags_r <= `BIR_RST_BYTE;
		end else if (item_in && last_item) begin
			// [RL11] set Z and N only
			flags_r[`BIR_FLAG_Z] <= 1'b1;
			flags_r[`BIR_FLAG_N] <= 1'b1;
		end else if (wr_hit(`BIR_OFS_FLAGS) && !BUSY_O) begin
			flags_r <= WDATA_I[7:0];
		end
	end

	// event pulses toward the core
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			BUSY_O <= 1'b0;
			DONE_O <= 1'b0;
			TRAP_O <= 1'b0;
			IRQ_TAKEN_O <= 1'b0;
			SAVED_PC_O <= `BIR_RST_POINTER;
		end else begin
			BUSY_O <= begin_ok || (BUSY_O && !(item_in && (last_item || IRQ_REQ_I)));
			DONE_O <= item_in && last_item;
			// [RL12] trap, no transfer
			TRAP_O <= begin_trap;
			IRQ_TAKEN_O <= item_in && !last_item && IRQ_REQ_I;
			// [RL10] restart address saved with the acceptance
			if (item_in && !last_item && IRQ_REQ_I) begin
				SAVED_PC_O <= pc_r;
			end
		end
	end

	// sticky status, set wins over write-one-to-clear
	assign ev = {item_in && !last_item && IRQ_REQ_I, begin_trap, item_in && last_item};

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			status_r <= `BIR_RST_STATUS;
			mask_r <= `BIR_RST_STATUS;
			INT_O <= 1'b0;
		end else begin
			if (wr_hit(`BIR_OFS_STATUS)) begin
				status_r <= (status_r & ~WDATA_I[`BIR_ST_W-1:0]) | ev;
			end else begin
				status_r <= status_r | ev;
			end
			if (wr_hit(`BIR_OFS_MASK)) begin
				mask_r <= WDATA_I[`BIR_ST_W-1:0];
			end
			// one cycle behind the status bit so the output stays a flop
			INT_O <= |(status_r & mask_r);
		end
	end

	// register read port, data one cycle after the strobe, unmapped reads zero
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			RDATA_O <= 32'h00000000;
		end else if (RD_I) begin
			unique case (ADDR_I)
				`BIR_OFS_CTRL: RDATA_O <= {30'h00000000, ctrl_r};
				`BIR_OFS_COUNT: RDATA_O <= {24'h000000, count_r};
				`BIR_OFS_PORT: RDATA_O <= {24'h000000, port_r};
				`BIR_OFS_PAGE: RDATA_O <= {24'h000000, page_r};
				`BIR_OFS_POINTER: RDATA_O <= {16'h0000, pointer_r};
				`BIR_OFS_FLAGS: RDATA_O <= {24'h000000, flags_r};
				`BIR_OFS_STATUS: RDATA_O <= {29'h00000000, status_r};
				`BIR_OFS_MASK: RDATA_O <= {29'h00000000, mask_r};
				`BIR_OFS_SAVED_PC: RDATA_O <= {16'h0000, SAVED_PC_O};
				default: RDATA_O <= 32'h00000000;
			endcase
		end else begin
			RDATA_O <= 32'h00000000;
		end
	end

	// checks
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RESET_I);

	logic [15:0] last_addr_r;
	logic seen_store_r;

	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I || begin_ok) begin
			seen_store_r <= 1'b0;
			last_addr_r <= 16'h0000;
		end else if (MEM_WR_O.we) begin
			seen_store_r <= 1'b1;
			last_addr_r <= MEM_WR_O.addr;
		end
	end

	property p_io_addr;
		IO_REQ_O.valid |-> (IO_REQ_O.addr[7:0] == port_r) && (IO_REQ_O.addr[15:8] == count_r) &&
			(IO_REQ_O.addr[23:16] == page_r);
	endproperty
	a_io_addr: assert property (p_io_addr) else $error("io address fields wrong"); // [RL3] [RL4]

	property p_count_dec;
		item_in |=> count_r == $past(count_r) - 8'h01;
	endproperty
	a_count_dec: assert property (p_count_dec) else $error("count not decremented"); // [RL1]

	property p_step;
		MEM_WR_O.we |-> pointer_r == MEM_WR_O.addr + (MEM_WR_O.word ? 16'h0002 : 16'h0001);
	endproperty
	a_step: assert property (p_step) else $error("pointer step wrong"); // [RL6]

	// consecutive rather than greater, so a pointer wrapping past FFFF still counts as ascending
	property p_ascend;
		MEM_WR_O.we && seen_store_r |-> MEM_WR_O.addr == last_addr_r + (MEM_WR_O.word ? 16'h0002 : 16'h0001);
	endproperty
	a_ascend: assert property (p_ascend) else $error("store address not ascending"); // [RL2]

	property p_store_data;
		item_in |=> MEM_WR_O.we && (MEM_WR_O.data[7:0] == $past(IO_RDATA_I[7:0]));
	endproperty
	a_store_data: assert property (p_store_data) else $error("stored data wrong"); // [RL5]

	property p_end;
		MEM_WR_O.we && (count_r == 8'h00) |-> DONE_O && !BUSY_O && !IO_REQ_O.valid;
	endproperty
	a_end: assert property (p_end) else $error("no end at zero count"); // [RL7]

	property p_again;
		item_in && !last_item && !IRQ_REQ_I |=> IO_REQ_O.valid && BUSY_O;
	endproperty
	a_again: assert property (p_again) else $error("next item not issued"); // [RL7]

	property p_flags;
		DONE_O |-> flags_r[`BIR_FLAG_Z] && flags_r[`BIR_FLAG_N] &&
			(flags_r[`BIR_FLAG_C] == $past(flags_r[`BIR_FLAG_C], 2));
	endproperty
	a_flags: assert property (p_flags) else $error("completion flags wrong"); // [RL11]

	property p_trap;
		begin_trap |=> TRAP_O && !BUSY_O && !IO_REQ_O.valid;
	endproperty
	a_trap: assert property (p_trap) else $error("inhibited transfer not trapped"); // [RL12]

	property p_sys_mode;
		START_I && insn.valid && !BUSY_O && !ctrl_r[`BIR_CTRL_USER] |=> !TRAP_O && IO_REQ_O.valid;
	endproperty
	a_sys_mode: assert property (p_sys_mode) else $error("system mode trapped"); // [RL15]

	property p_irq;
		IRQ_TAKEN_O |-> (SAVED_PC_O == pc_r) && !BUSY_O && (count_r != 8'h00);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt acceptance wrong"); // [RL9] [RL10]

	property p_decode;
		START_I && !BUSY_O && (PREFIX_I == `BIR_PREFIX) && (OPCODE_I == `BIR_OP_WORDS) &&
			!ctrl_r[`BIR_CTRL_USER] |=> IO_REQ_O.word;
	endproperty
	a_decode: assert property (p_decode) else $error("word form not decoded"); // [RL14]

	c_full_run: cover property (DONE_O);
	c_wrap: cover property (begin_ok && (count_r == 8'h00));
	c_suspend: cover property (IRQ_TAKEN_O);
	c_trap: cover property (TRAP_O);

endmodule

// ### inc/block_input_regs.svh
// register offsets, field positions and reset values of the block input engine
`ifndef BLOCK_INPUT_REGS_SVH
`define BLOCK_INPUT_REGS_SVH

`define BIR_ADDR_W 8
`define BIR_OFS_CTRL 8'h00
`define BIR_OFS_COUNT 8'h04
`define BIR_OFS_PORT 8'h08
`define BIR_OFS_PAGE 8'h0C
`define BIR_OFS_POINTER 8'h10
`define BIR_OFS_FLAGS 8'h14
`define BIR_OFS_STATUS 8'h18
`define BIR_OFS_MASK 8'h1C
`define BIR_OFS_SAVED_PC 8'h20

// control register fields
`define BIR_CTRL_USER 0
`define BIR_CTRL_INHIBIT 1

// status and mask fields
`define BIR_ST_DONE 0
`define BIR_ST_TRAP 1
`define BIR_ST_SUSPEND 2
`define BIR_ST_W 3

// flag register fields
`define BIR_FLAG_S 7
`define BIR_FLAG_Z 6
`define BIR_FLAG_H 4
`define BIR_FLAG_V 2
`define BIR_FLAG_N 1
`define BIR_FLAG_C 0

// instruction encodings
`define BIR_PREFIX 8'hED
`define BIR_OP_BYTES 8'hB2
`define BIR_OP_WORDS 8'h92

// reset values
`define BIR_RST_CTRL 2'h0
`define BIR_RST_BYTE 8'h00
`define BIR_RST_POINTER 16'h0000
`define BIR_RST_STATUS 3'h0

`endif

// ### inc/block_input_pkg.sv
// types shared by the block input engine and its decoder
package block_input_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT
	} state_t;

	// one input transaction on the system bus
	typedef struct packed {
		logic valid;
		logic word;
		logic [23:0] addr;
	} io_req_t;

	// one store into data memory
	typedef struct packed {
		logic we;
		logic word;
		logic [15:0] addr;
		logic [15:0] data;
	} mem_wr_t;

	// decoded instruction
	typedef struct packed {
		logic valid;
		logic word;
	} insn_t;

endpackage

// ### hdl/block_input_decode.sv
// decoder of the repeating block input instruction pair
`timescale 1ns/10ps
`include "block_input_regs.svh"

module block_input_decode (
	input wire logic [7:0] prefix_i,
	input wire logic [7:0] opcode_i,
	output block_input_pkg::insn_t insn_o
);

	always_comb begin
		insn_o = '0;
		if (prefix_i == `BIR_PREFIX) begin
			// [RL13] byte form
			if (opcode_i == `BIR_OP_BYTES) begin
				insn_o.valid = 1'b1;
				insn_o.word = 1'b0;
			end
			// [RL14] word form
			if (opcode_i == `BIR_OP_WORDS) begin
				insn_o.valid = 1'b1;
				insn_o.word = 1'b1;
			end
		end
	end

endmodule

// ### verification/io_peripheral_model.sv
// behavioural peripheral answering each input transaction after a chosen delay
`timescale 1ns/10ps

module io_peripheral_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire block_input_pkg::io_req_t req_i,
	input wire logic [1:0] dly_i,
	output logic rvalid_o,
	output logic [15:0] rdata_o
);
	logic pend_r;
	logic [1:0] wait_r;
	logic [15:0] addr_r;

	// one answer per request, in order
	always @(posedge clk_i) begin
		rvalid_o <= 1'b0;
		// released data lines toggle so a stale item is never mistaken for a fresh one
		rdata_o <= ~rdata_o;
		if (rst_i) begin
			pend_r <= 1'b0;
			rdata_o <= 16'h0000;
		end else if (req_i.valid) begin
			addr_r <= req_i.addr[15:0];
			wait_r <= dly_i;
			pend_r <= 1'b1;
		end else if (pend_r && wait_r == 2'h0) begin
			pend_r <= 1'b0;
			rvalid_o <= 1'b1;
			rdata_o <= addr_r ^ 16'h5A3C;
		end else if (pend_r) begin
			wait_r <= wait_r - 2'h1;
		end
	end
endmodule

// ### verification/block_input_repeat_tb_top.sv
// self-checking bench of the repeating block input engine
`timescale 1ns/10ps
`include "block_input_regs.svh"

module block_input_repeat_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic rd_d = 1'b0;
	logic [31:0] rdata;
	logic start = 1'b0;
	logic [7:0] prefix = 8'h00;
	logic [7:0] opcode = 8'h00;
	logic [15:0] pc = 16'h0000;
	logic [15:0] pc_v = 16'h1234;
	logic irq_req = 1'b0;
	logic rvalid;
	logic [15:0] io_data;
	logic [1:0] dly = 2'h0;
	block_input_pkg::io_req_t io_req;
	block_input_pkg::mem_wr_t mem_wr;
	logic busy;
	logic done;
	logic trap;
	logic irq_taken;
	logic irq_line;
	logic [15:0] saved_pc;
	logic [2:0] ends = 3'b000;
	logic [7:0] port_v = 8'h64;
	logic [7:0] page_v = 8'h33;
	int err_count = 0;
	int checked = 0;
	int seed = 82856;
	logic [24:0] ioq[$];
	logic [33:0] mq[$];
	logic [31:0] rq[$];

	always #4 clk = ~clk;

	block_input_repeat u_dut (.SYS_CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
		.RD_I(rd_s), .RDATA_O(rdata), .START_I(start), .PREFIX_I(prefix), .OPCODE_I(opcode), .PC_I(pc),
		.IRQ_REQ_I(irq_req), .IO_RVALID_I(rvalid), .IO_RDATA_I(io_data), .IO_REQ_O(io_req), .MEM_WR_O(mem_wr),
		.BUSY_O(busy), .DONE_O(done), .TRAP_O(trap), .IRQ_TAKEN_O(irq_taken), .SAVED_PC_O(saved_pc),
		.INT_O(irq_line));

	io_peripheral_model u_periph (.clk_i(clk), .rst_i(rst), .req_i(io_req), .dly_i(dly), .rvalid_o(rvalid),
		.rdata_o(io_data));

	task finish_test();
		if (err_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask

	always @(posedge clk) rd_d <= rd_s;

	// end pulses are latched so a waiter never misses a one-cycle flag
	always @(negedge clk) begin
		ends = ends | {done, irq_taken, trap};
		if (rd_d) chk(rdata, rq.pop_front());
		if (io_req.valid) chk({io_req.word, io_req.addr}, ioq.size() > 0 ? ioq.pop_front() : 'x);
		if (mem_wr.we) chk(mem_wr, mq.size() > 0 ? mq.pop_front() : 'x);
	end

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp);
		rq.push_back(exp);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
	endtask

	task go(input logic [7:0] pre, input logic [7:0] op, input logic irq);
		@(posedge clk);
		ends = 3'b000;
		start <= 1'b1;
		prefix <= pre;
		opcode <= op;
		pc <= pc_v;
		irq_req <= irq;
		@(posedge clk);
		start <= 1'b0;
	endtask

	task run(input logic [7:0] op, input logic [7:0] cnt, input logic [15:0] ptr, input int k, input logic irq,
		input logic [2:0] fin);
		logic [7:0] c;
		logic [15:0] d;
		logic [23:0] a;
		int n;
		c = cnt;
		// ascending pointer, one or two per item
		for (int i = 0; i < k; i++) begin
			a = {page_v, c, port_v};
			ioq.push_back({op == `BIR_OP_WORDS, a});
			d = a[15:0] ^ 16'h5A3C;
			if (op == `BIR_OP_BYTES) d = {8'h00, d[7:0]};
			mq.push_back({1'b1, op == `BIR_OP_WORDS, ptr + 16'(i * (op == `BIR_OP_WORDS ? 2 : 1)), d});
			c = c - 8'h01;
		end
		go(`BIR_PREFIX, op, irq);
		n = 0;
		while (ends === 3'b000 && n < 3000) begin
			@(negedge clk);
			n++;
		end
		chk(ends, fin);
		if (n == 3000) finish_test();
	endtask

	initial begin
		logic [7:0] cnt;
		logic [15:0] ptr;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 9; i++) rd(8'(4 * i), 32'h0);
		rd(8'h3C, 32'h0);
		wr(`BIR_OFS_PORT, port_v);
		wr(`BIR_OFS_PAGE, page_v);
		wr(`BIR_OFS_COUNT, 32'h2);
		wr(`BIR_OFS_POINTER, 32'h5002);
		wr(`BIR_OFS_FLAGS, 32'h95);
		wr(`BIR_OFS_MASK, 32'h1);
		run(`BIR_OP_BYTES, 8'h02, 16'h5002, 2, 1'b0, 3'b100);
		repeat (2) @(negedge clk);
		chk(irq_line, 1'b1);
		rd(`BIR_OFS_COUNT, 32'h0);
		rd(`BIR_OFS_POINTER, 32'h5004);
		rd(`BIR_OFS_FLAGS, 32'hD7);
		wr(`BIR_OFS_STATUS, 32'h7);
		repeat (2) @(negedge clk);
		chk(irq_line, 1'b0);
		repeat (3) begin
			cnt = 8'(($random(seed) & 3) + 1);
			ptr = 16'($random(seed));
			dly = 2'($random(seed));
			port_v = 8'($random(seed));
			page_v = 8'($random(seed));
			wr(`BIR_OFS_PORT, port_v);
			wr(`BIR_OFS_PAGE, page_v);
			wr(`BIR_OFS_COUNT, cnt);
			wr(`BIR_OFS_POINTER, ptr);
			run(`BIR_OP_WORDS, cnt, ptr, int'(cnt), 1'b0, 3'b100);
			rd(`BIR_OFS_POINTER, ptr + {7'h00, cnt, 1'b0});
		end
		dly = 2'h0;
		wr(`BIR_OFS_POINTER, 32'hFF80);
		run(`BIR_OP_BYTES, 8'h00, 16'hFF80, 256, 1'b0, 3'b100);
		rd(`BIR_OFS_POINTER, 32'h0080);
		wr(`BIR_OFS_COUNT, 32'h3);
		wr(`BIR_OFS_POINTER, 32'h2000);
		run(`BIR_OP_BYTES, 8'h03, 16'h2000, 1, 1'b1, 3'b010);
		chk(saved_pc, pc_v);
		rd(`BIR_OFS_SAVED_PC, pc_v);
		run(`BIR_OP_BYTES, 8'h02, 16'h2001, 2, 1'b0, 3'b100);
		wr(`BIR_OFS_COUNT, 32'h1);
		wr(`BIR_OFS_POINTER, 32'h2100);
		run(`BIR_OP_BYTES, 8'h01, 16'h2100, 1, 1'b1, 3'b100);
		wr(`BIR_OFS_STATUS, 32'h7);
		wr(`BIR_OFS_MASK, 32'h2);
		wr(`BIR_OFS_CTRL, 32'h3);
		run(`BIR_OP_BYTES, 8'h00, 16'h0000, 0, 1'b0, 3'b001);
		repeat (2) @(negedge clk);
		chk(irq_line, 1'b1);
		wr(`BIR_OFS_MASK, 32'h0);
		repeat (2) @(negedge clk);
		chk(irq_line, 1'b0);
		wr(`BIR_OFS_CTRL, 32'h2);
		wr(`BIR_OFS_COUNT, 32'h1);
		wr(`BIR_OFS_POINTER, 32'h0300);
		run(`BIR_OP_BYTES, 8'h01, 16'h0300, 1, 1'b0, 3'b100);
		go(8'hEC, `BIR_OP_BYTES, 1'b0);
		go(`BIR_PREFIX, 8'hB3, 1'b0);
		repeat (4) @(negedge clk);
		chk(busy, 1'b0);
		chk(ends, 3'b000);
		chk(ioq.size() + mq.size(), 0);
		finish_test();
	end
endmodule
